// [hw/fsr_top.sv]
// Flash security, reset load sequence and command completion control
//
// Function
// RULE1 - security state reloaded from security byte each reset
// RULE2 - backdoor unlock leaves protection image untouched
// RULE3 - no backdoor unlock in special single chip mode
// RULE4 - host erases via special mode, mass erase
// RULE5 - secure ROM blank check sets unsecured status
// RULE6 - host programs security byte then resets
// RULE7 - reset load sequence stalls CPU while loading
// RULE8 - reset aborts an active flash command
// RULE9 - interrupt when commands done, buffers empty
// RULE10 - mask bit gates the completion interrupt
`timescale 1ns/1ps
`include "fsr_consts.svh"
module fsr_top (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    input  wire logic [`FSR_RA_W-1:0]  reg_addr,
    input  wire logic [`FSR_DW-1:0]    reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [`FSR_DW-1:0]    reg_rdata,
    input  wire logic                  special_mode_pin,
    output fsr_pkg::fsr_freq_s         fa_req,
    output logic                       fa_valid,
    input  wire logic                  fa_done,
    input  wire logic [`FSR_DW-1:0]    fa_rdata,
    output logic                       fa_abort,
    output logic                       cpu_hold,
    output logic                       secured,
    output logic                       unsecured_status_bit,
    output logic                       command_complete_flag,
    output logic                       irq
);
    // ****************************************
    // State
    // ****************************************
    fsr_pkg::fsr_state_e        st_q, st_d;
    fsr_pkg::fsr_freq_s         req_q, req_d;
    logic                       fv_q, fv_d, abort_q, abort_d, hold_q, hold_d;
    logic                       spec_m_q, spec_q;
    logic [7:0]                 prot_q, prot_d, ctl_q, ctl_d, sec_q, sec_d;
    logic [`FSR_DW-1:0]         key_q, key_d, data_q, data_d, rd_q, rd_d;
    logic [`FSR_FA_W-1:0]       addr_q, addr_d;
    logic [7:0]                 cmd_q, cmd_d;
    logic                       af_q, af_d, df_q, df_d, act_q, act_d;
    logic                       bkd_q, bkd_d, blank_q, blank_d, sc_q, sc_d;
    logic                       ccf_q, ccf_d, irq_q, irq_d;
    logic [1:0]                 ist_q, ist_d, imask_q, imask_d, iset;
    logic [`FSR_FA_W-1:0]       ld_addr;

    // Location read in each load state
    always_comb begin
        case (st_q)
            fsr_pkg::ST_PROT: ld_addr = `FSR_PROT_LOC;
            fsr_pkg::ST_CTL:  ld_addr = `FSR_CTL_LOC;
            fsr_pkg::ST_SEC:  ld_addr = `FSR_SEC_LOC;
            default:          ld_addr = `FSR_KEY_LOC;
        endcase
    end

    // ****************************************
    // Next state: load sequence, commands, registers
    // ****************************************
    always_comb begin
        st_d    = st_q;
        req_d   = req_q;
        fv_d    = fv_q;
        abort_d = 1'b0;
        hold_d  = hold_q;
        prot_d  = prot_q;
        ctl_d   = ctl_q;
        sec_d   = sec_q;
        key_d   = key_q;
        data_d  = data_q;
        addr_d  = addr_q;
        cmd_d   = cmd_q;
        af_d    = af_q;
        df_d    = df_q;
        act_d   = act_q;
        bkd_d   = bkd_q;
        blank_d = blank_q;
        imask_d = imask_q;
        iset    = 2'h0;
        rd_d    = '0;
        if (sys_rst) begin
            // Abort whatever is running; the word or sector is left undefined
            abort_d = act_q | fv_q;                       // [RULE8]
            fv_d    = 1'b0;                               // [RULE8]
            act_d   = 1'b0;                               // [RULE8]
            st_d    = fsr_pkg::ST_PROT;                   // [RULE7]
            hold_d  = 1'b1;                               // [RULE7]
            bkd_d   = 1'b0;                               // [RULE1]
            blank_d = 1'b0;
            prot_d  = `FSR_IMG_RST;
            ctl_d   = `FSR_IMG_RST;
            sec_d   = `FSR_IMG_RST;
            key_d   = '0;
            af_d    = 1'b0;
            df_d    = 1'b0;
            cmd_d   = '0;
            imask_d = 2'h0;
        end else begin
            case (st_q)
                // Images are fetched one word at a time while the CPU waits
                fsr_pkg::ST_PROT, fsr_pkg::ST_CTL, fsr_pkg::ST_SEC, fsr_pkg::ST_KEY: begin
                    if (!fv_q) begin
                        fv_d       = 1'b1;                // [RULE7]
                        req_d.op   = fsr_pkg::FA_READ;
                        req_d.addr = ld_addr;
                        req_d.wdata = '0;
                    end else if (fa_done) begin
                        fv_d = 1'b0;
                        case (st_q)
                            fsr_pkg::ST_PROT: begin
                                prot_d = fa_rdata[7:0];   // [RULE7]
                                st_d   = fsr_pkg::ST_CTL;
                            end
                            fsr_pkg::ST_CTL: begin
                                ctl_d = fa_rdata[7:0];    // [RULE7]
                                st_d  = fsr_pkg::ST_SEC;
                            end
                            fsr_pkg::ST_SEC: begin
                                sec_d = fa_rdata[7:0];    // [RULE1] [RULE7]
                                st_d  = fsr_pkg::ST_KEY;
                            end
                            default: begin
                                key_d = fa_rdata;
                                st_d  = spec_q ? fsr_pkg::ST_ROM : fsr_pkg::ST_RUN;
                            end
                        endcase
                    end
                end
                // Secure ROM blank check, only in special single chip mode
                fsr_pkg::ST_ROM: begin
                    if (!fv_q) begin
                        fv_d      = 1'b1;
                        req_d.op  = fsr_pkg::FA_BLANK;
                    end else if (fa_done) begin
                        fv_d    = 1'b0;
                        blank_d = fa_rdata[0];            // [RULE5]
                        st_d    = fsr_pkg::ST_RUN;
                    end
                end
                fsr_pkg::ST_RUN: begin
                    hold_d = 1'b0;
                    if (act_q && fa_done) begin
                        act_d = 1'b0;
                        fv_d  = 1'b0;
                    end
                end
                default: st_d = fsr_pkg::ST_PROT;
            endcase

            // Register writes; buffers only load while no command runs
            if (reg_wr) begin
                if (reg_addr == `FSR_R_ADDR_HI && !act_q) begin
                    addr_d[`FSR_FA_W-1:`FSR_DW] = reg_wdata[`FSR_FA_W-`FSR_DW-1:0];
                end else if (reg_addr == `FSR_R_ADDR_LO && !act_q) begin
                    addr_d[`FSR_DW-1:0] = reg_wdata;
                    af_d = 1'b1;
                end else if (reg_addr == `FSR_R_DATA && !act_q) begin
                    data_d = reg_wdata;
                    df_d   = 1'b1;
                end else if (reg_addr == `FSR_R_CMD) begin
                    cmd_d = reg_wdata[7:0];
                    if (act_q || st_q != fsr_pkg::ST_RUN) begin
                        iset[`FSR_INT_ERR] = 1'b1;
                    end else if (reg_wdata[7:0] == `FSR_CMD_PROG && af_q && df_q) begin
                        act_d       = 1'b1;
                        fv_d        = 1'b1;
                        req_d.op    = fsr_pkg::FA_PROG;
                        req_d.addr  = addr_q;
                        req_d.wdata = data_q;
                        af_d        = 1'b0;
                        df_d        = 1'b0;
                    end else if (reg_wdata[7:0] == `FSR_CMD_MERASE
                                 && prot_q == `FSR_PROT_OPEN) begin
                        // Mass erase only while the protection image reads open (8'hFF), whether written by the host or loaded at reset
                        act_d      = 1'b1;                // [RULE4]
                        fv_d       = 1'b1;
                        req_d.op   = fsr_pkg::FA_MERASE;
                        req_d.addr = addr_q;
                        af_d       = 1'b0;
                        df_d       = 1'b0;
                    end else begin
                        iset[`FSR_INT_ERR] = 1'b1;
                    end
                end else if (reg_addr == `FSR_R_INT_MASK) begin
                    imask_d = reg_wdata[1:0];             // [RULE10]
                end else if (reg_addr == `FSR_R_KEY && st_q == fsr_pkg::ST_RUN) begin
                    // Protection image is not touched by an unlock
                    if (!spec_q && reg_wdata == key_q) begin
                        bkd_d = 1'b1;                     // [RULE2] [RULE3]
                    end
                end else if (reg_addr == `FSR_R_PROT && !act_q) begin
                    prot_d = reg_wdata[7:0];
                end
            end

            // Read data, returned in the following cycle
            if (reg_rd) begin
                if (reg_addr == `FSR_R_ADDR_HI) begin
                    rd_d[`FSR_FA_W-`FSR_DW-1:0] = addr_q[`FSR_FA_W-1:`FSR_DW];
                end else if (reg_addr == `FSR_R_ADDR_LO) begin
                    rd_d = addr_q[`FSR_DW-1:0];
                end else if (reg_addr == `FSR_R_DATA) begin
                    rd_d = data_q;
                end else if (reg_addr == `FSR_R_CMD) begin
                    rd_d[7:0] = cmd_q;
                end else if (reg_addr == `FSR_R_STATUS) begin
                    rd_d[5:0] = {blank_q, secured, spec_q, bkd_q, act_q, ccf_q};
                end else if (reg_addr == `FSR_R_INT_STAT) begin
                    rd_d[1:0] = ist_q;
                end else if (reg_addr == `FSR_R_INT_MASK) begin
                    rd_d[1:0] = imask_q;
                end else if (reg_addr == `FSR_R_PROT) begin
                    rd_d[7:0] = prot_q;
                end else if (reg_addr == `FSR_R_CTL) begin
                    rd_d[7:0] = ctl_q;
                end else if (reg_addr == `FSR_R_SEC) begin
                    rd_d[7:0] = sec_q;
                end
            end
        end
    end

    // Completion flag and sticky interrupt status; a set beats a clear
    always_comb begin
        ccf_d = !act_d && !af_d && !df_d;                 // [RULE9]
        ist_d = ist_q;
        sc_d  = (sec_d[1:0] != `FSR_SEC_OPEN) && !bkd_d && !blank_d;  // [RULE1] [RULE5]
        if (sys_rst) begin
            ist_d = 2'h0;
        end else begin
            if (reg_wr && reg_addr == `FSR_R_INT_STAT) begin
                ist_d = ist_q & ~reg_wdata[1:0];
            end
            ist_d = ist_d | iset;
            if (ccf_d && !ccf_q) begin
                ist_d[`FSR_INT_DONE] = 1'b1;              // [RULE9]
            end
        end
        irq_d = |(ist_d & imask_d);                       // [RULE9] [RULE10]
    end

    // ****************************************
    // Registers; clock enable freezes everything
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            spec_m_q <= special_mode_pin;                 // Pin is asynchronous
            spec_q   <= spec_m_q;
            st_q     <= st_d;
            req_q    <= req_d;
            fv_q     <= fv_d;
            abort_q  <= abort_d;
            hold_q   <= hold_d;
            prot_q   <= prot_d;
            ctl_q    <= ctl_d;
            sec_q    <= sec_d;
            key_q    <= key_d;
            data_q   <= data_d;
            addr_q   <= addr_d;
            cmd_q    <= cmd_d;
            af_q     <= af_d;
            df_q     <= df_d;
            act_q    <= act_d;
            bkd_q    <= bkd_d;
            blank_q  <= blank_d;
            sc_q     <= sc_d;
            ccf_q    <= ccf_d;
            ist_q    <= ist_d;
            imask_q  <= imask_d;
            irq_q    <= irq_d;
            rd_q     <= rd_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata             = rd_q;
    assign fa_req                = req_q;
    assign fa_valid              = fv_q;
    assign fa_abort              = abort_q;
    assign cpu_hold              = hold_q;
    assign secured               = sc_q;
    assign unsecured_status_bit  = blank_q;
    assign command_complete_flag = ccf_q;
    assign irq                   = irq_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    load_hold_a: assert property (st_q != fsr_pkg::ST_RUN |-> cpu_hold) // [RULE7]
        else $error("CPU not held during load");
    reset_abort_a: assert property (@(posedge core_clk) disable iff (1'b0) // [RULE8]
        (sys_rst && clk_en && act_q) |=> (fa_abort && !fa_valid && !act_q))
        else $error("Reset did not abort command");
    reset_relock_a: assert property (@(posedge core_clk) disable iff (1'b0) // [RULE1]
        (sys_rst && clk_en) |=> (!bkd_q && st_q == fsr_pkg::ST_PROT))
        else $error("Unlock survived reset");
    sec_load_a: assert property ((clk_en && st_q == fsr_pkg::ST_SEC && fa_done && fv_q) // [RULE1]
        |=> sec_q == $past(fa_rdata[7:0]))
        else $error("Security image not loaded");
    prot_keep_a: assert property ((clk_en && !bkd_q && bkd_d) |=> $stable(prot_q)) // [RULE2]
        else $error("Unlock changed protection");
    special_refuse_a: assert property ((clk_en && spec_q && !bkd_q) |=> !bkd_q) // [RULE3]
        else $error("Unlocked in special mode");
    rom_blank_a: assert property ((clk_en && st_q == fsr_pkg::ST_ROM && fv_q // [RULE5]
        && fa_done && fa_rdata[0]) |=> (blank_q && st_q == fsr_pkg::ST_RUN) ##1 !secured)
        else $error("Blank check did not unsecure");
    done_flag_a: assert property ((clk_en && st_q == fsr_pkg::ST_RUN && act_q // [RULE9]
        && fa_done && !af_q && !df_q && !(reg_wr && clk_en))
        |=> (command_complete_flag && ist_q[`FSR_INT_DONE]))
        else $error("Completion not flagged");
    irq_gate_a: assert property (irq == |(ist_q & imask_q)) // [RULE10]
        else $error("Interrupt not gated by mask");
endmodule : fsr_top

// [hw/fsr_consts.svh]
// Offsets, field positions, reset values and codes for the flash security and reset control
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH
// ****************************************
// Widths
// ****************************************
`define FSR_FA_W        23
`define FSR_RA_W        4
`define FSR_DW          16
// ****************************************
// Flash array locations read by the load sequence
// ****************************************
`define FSR_KEY_LOC     23'h7F_FF00
`define FSR_PROT_LOC    23'h7F_FF0D
`define FSR_CTL_LOC     23'h7F_FF0E
`define FSR_SEC_LOC     23'h7F_FF0F
// ****************************************
// Register offsets
// ****************************************
`define FSR_R_ADDR_HI   4'h0
`define FSR_R_ADDR_LO   4'h1
`define FSR_R_DATA      4'h2
`define FSR_R_CMD       4'h3
`define FSR_R_STATUS    4'h4
`define FSR_R_INT_STAT  4'h5
`define FSR_R_INT_MASK  4'h6
`define FSR_R_KEY       4'h7
`define FSR_R_PROT      4'h8
`define FSR_R_CTL       4'h9
`define FSR_R_SEC       4'hA
// ****************************************
// Commands, field values and reset values
// ****************************************
`define FSR_CMD_PROG    8'h20
`define FSR_CMD_MERASE  8'h41
`define FSR_SEC_OPEN    2'h2
`define FSR_PROT_OPEN   8'hFF
`define FSR_INT_DONE    0
`define FSR_INT_ERR     1
`define FSR_IMG_RST     8'h00
`endif

// [hw/fsr_pkg.sv]
// Types shared by the flash security and reset control
`include "fsr_consts.svh"
package fsr_pkg;
    typedef enum logic [5:0] {
        ST_PROT = 6'h01,
        ST_CTL  = 6'h02,
        ST_SEC  = 6'h04,
        ST_KEY  = 6'h08,
        ST_ROM  = 6'h10,
        ST_RUN  = 6'h20
    } fsr_state_e;
    typedef enum logic [1:0] {
        FA_READ   = 2'h0,
        FA_PROG   = 2'h1,
        FA_MERASE = 2'h2,
        FA_BLANK  = 2'h3
    } fsr_op_e;
    typedef struct packed {
        fsr_op_e                 op;
        logic [`FSR_FA_W-1:0]    addr;
        logic [`FSR_DW-1:0]      wdata;
    } fsr_freq_s;
endpackage : fsr_pkg

// [sim/fsr_flash_model.sv]
// Behavioural flash array that answers load reads, program, mass erase and blank check
`timescale 1ns/1ps
`include "fsr_consts.svh"
module fsr_flash_model #(
    parameter logic [15:0] KEY_VAL = 16'hA5C3, // Arbitrary backdoor key word
    parameter logic [15:0] SEC_VAL = 16'h0000
) (
    input  wire logic               core_clk,
    input  wire fsr_pkg::fsr_freq_s fa_req,
    input  wire logic               fa_valid,
    input  wire logic               fa_abort,
    input  wire logic               slow,
    output logic                    fa_done,
    output logic [`FSR_DW-1:0]      fa_rdata
);
    logic [`FSR_DW-1:0] mem [int];
    logic [`FSR_DW-1:0] rd_q;
    int                 cnt;
    // Contents survive every reset, as real flash does
    initial begin
        mem[`FSR_PROT_LOC] = 16'h0000;
        mem[`FSR_CTL_LOC]  = 16'h0055;
        mem[`FSR_SEC_LOC]  = SEC_VAL;
        mem[`FSR_KEY_LOC]  = KEY_VAL;
        fa_done = 1'b0;
        rd_q    = 16'h0000;
        cnt     = 0;
    end
    // Data is only valid with the done pulse; otherwise show the inverse
    assign fa_rdata = fa_done ? rd_q : ~rd_q;
    // One request at a time; an abort drops the operation uncommitted
    always @(posedge core_clk) begin
        if (fa_abort || fa_done || !fa_valid) begin
            fa_done <= 1'b0;
            cnt     <= 0;
        end else if (cnt >= (slow ? 12 : 1)) begin
            fa_done <= 1'b1;
            cnt     <= 0;
            case (fa_req.op)
                fsr_pkg::FA_READ: rd_q <= mem.exists(fa_req.addr) ? mem[fa_req.addr] : 16'hFFFF;
                fsr_pkg::FA_PROG: mem[fa_req.addr] = fa_req.wdata;
                fsr_pkg::FA_MERASE: foreach (mem[i]) mem[i] = 16'hFFFF;
                default: begin
                    rd_q <= 16'h0001;
                    foreach (mem[i]) if (mem[i] !== 16'hFFFF) rd_q <= 16'h0000;
                end
            endcase
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : fsr_flash_model

// [sim/flash_security_reset_control_tb.sv]
// Self-checking bench for the flash security, reset load and completion control
`timescale 1ns/1ps
`include "fsr_consts.svh"
module flash_security_reset_control_tb;
    localparam logic [15:0] KEY_VAL = 16'hA5C3; // Arbitrary key word
    logic                      core_clk = 1'b0;
    logic                      sys_rst = 1'b1;
    logic [`FSR_RA_W-1:0]      reg_addr = 4'h0;
    logic [`FSR_DW-1:0]        reg_wdata = 16'h0000;
    logic                      reg_wr = 1'b0;
    logic                      reg_rd = 1'b0;
    logic                      clk_en = 1'b1;
    logic [`FSR_DW-1:0]        reg_rdata;
    logic                      special_mode_pin = 1'b0;
    fsr_pkg::fsr_freq_s        fa_req;
    logic                      fa_valid, fa_done, fa_abort, slow = 1'b0;
    logic [`FSR_DW-1:0]        fa_rdata, d;
    logic                      cpu_hold, secured, unsecured_status_bit;
    logic                      command_complete_flag, irq;
    int                        mismatches = 0, compares = 0, cycles = 0;
    int                        loads = 0, aborts = 0, base, seed;

    fsr_top fsr_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .special_mode_pin(special_mode_pin), .fa_req(fa_req),
        .fa_valid(fa_valid), .fa_done(fa_done), .fa_rdata(fa_rdata), .fa_abort(fa_abort),
        .cpu_hold(cpu_hold), .secured(secured), .unsecured_status_bit(unsecured_status_bit),
        .command_complete_flag(command_complete_flag), .irq(irq));
    fsr_flash_model #(.KEY_VAL(KEY_VAL), .SEC_VAL(16'h0000)) fsr_flash_model_i (
        .core_clk(core_clk), .fa_req(fa_req), .fa_valid(fa_valid), .fa_abort(fa_abort),
        .slow(slow), .fa_done(fa_done), .fa_rdata(fa_rdata));

    // ****************************************
    // Clock, monitors and hang guard
    // ****************************************
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // Array reads finished while the CPU is held, and abort pulses seen
    always @(posedge core_clk) begin
        cycles++;
        if (fa_done && fa_valid && cpu_hold) loads++;
        if (fa_abort) aborts++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic wait_for(input bit hold);
        for (int i = 0; i < 400 && (hold ? cpu_hold !== 1'b0 : command_complete_flag !== 1'b1);
             i++) begin
            @(posedge core_clk);
            #1;
        end
        // A limit that runs out is a failure, never a silent pass
        if (hold ? cpu_hold !== 1'b0 : command_complete_flag !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: wait limit reached", $time);
        end
    endtask : wait_for
    // Reset for four cycles, then let the load sequence run out
    task automatic do_reset(input logic spec);
        @(posedge core_clk);
        special_mode_pin <= spec; sys_rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        base = loads;
        #1 chk(32'(cpu_hold), 32'd1);
        wait_for(1'b1);
        chk(32'(loads - base), spec ? 32'd5 : 32'd4);
    endtask : do_reset
    task automatic complete_run;
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 65;
        do_reset(1'b0);
        chk(32'(secured), 32'd1);
        // A wrong random key must leave the part secured
        d = 16'($random(seed));
        if (d == KEY_VAL) d = ~d;
        wr(`FSR_R_KEY, d);
        settle();
        chk(32'(secured), 32'd1);
        wr(`FSR_R_KEY, KEY_VAL);
        settle();
        chk(32'(secured), 32'd0);
        rd(`FSR_R_PROT, d);
        chk(32'(d[7:0]), 32'h0000_0000);
        rd(`FSR_R_CTL, d);
        chk(32'(d), 32'h0000_0055);
        do_reset(1'b0);
        chk(32'(secured), 32'd1);
        // Special mode: key refused, array not blank yet
        do_reset(1'b1);
        wr(`FSR_R_KEY, KEY_VAL);
        settle();
        chk(32'(secured), 32'd1);
        chk(32'(unsecured_status_bit), 32'd0);
        // Erase while protected and a random bad code both flag an error
        wr(`FSR_R_INT_MASK, 16'h0000);
        wr(`FSR_R_CMD, 16'h0041);
        wr(`FSR_R_CMD, {8'h00, 8'($random(seed)) | 8'h80});
        settle();
        rd(`FSR_R_INT_STAT, d);
        chk(32'(d[1]), 32'd1);
        wr(`FSR_R_INT_STAT, 16'h0003);
        wr(`FSR_R_PROT, 16'h00FF);
        wr(`FSR_R_CMD, 16'h0041);
        #1 chk(32'(fa_valid), 32'd1);
        chk(32'(fa_req.op), 32'(fsr_pkg::FA_MERASE));
        chk(32'(command_complete_flag), 32'd0);
        wait_for(1'b0);
        settle();
        rd(`FSR_R_INT_STAT, d);
        chk(32'(d[0]), 32'd1);
        chk(32'(irq), 32'd0);
        wr(`FSR_R_INT_MASK, 16'h0001);
        settle();
        chk(32'(irq), 32'd1);
        wr(`FSR_R_INT_STAT, 16'h0001);
        settle();
        chk(32'(irq), 32'd0);
        // Clock enable low: a write must not land while all state is frozen
        clk_en <= 1'b0;
        wr(`FSR_R_INT_MASK, 16'h0003);
        clk_en <= 1'b1;
        rd(`FSR_R_INT_MASK, d);
        chk(32'(d[1:0]), 32'd1);
        // Blank array found by the secure check on the next special reset
        do_reset(1'b1);
        chk(32'(unsecured_status_bit), 32'd1);
        chk(32'(secured), 32'd0);
        // Status: blank found, open, special mode, no backdoor, idle, complete
        rd(`FSR_R_STATUS, d);
        chk(32'(d), 32'h0000_0029);
        // Host writes the open value into the security byte
        wr(`FSR_R_ADDR_HI, 16'h007F);
        wr(`FSR_R_ADDR_LO, 16'hFF0F);
        wr(`FSR_R_DATA, 16'hFFFE);
        wr(`FSR_R_CMD, 16'h0020);
        #1 chk(32'(fa_req.addr), 32'(`FSR_SEC_LOC));
        wait_for(1'b0);
        do_reset(1'b0);
        chk(32'(secured), 32'd0);
        rd(`FSR_R_SEC, d);
        chk(32'(d[1:0]), 32'(`FSR_SEC_OPEN));
        // Slow program of a random word cut short by reset
        slow <= 1'b1;
        wr(`FSR_R_ADDR_HI, 16'h0000);
        wr(`FSR_R_ADDR_LO, 16'($random(seed)) & 16'h0FFF);
        wr(`FSR_R_DATA, 16'($random(seed)));
        wr(`FSR_R_CMD, 16'h0020);
        base = aborts;
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1 chk(32'(aborts - base), 32'd1);
        chk(32'(fa_valid), 32'd0);
        wait_for(1'b1);
        chk(32'(cpu_hold), 32'd0);
        complete_run();
    end
endmodule : flash_security_reset_control_tb
